// ---- shared/pdt_pkg.sv ----
// Register map, field positions, timing-free constants and state types of the PCI DMA and target bridge.
package pdt_pkg;
  // Register byte offsets on the APB side.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ICFG = 8'h04;
  localparam logic [7:0] OFF_EVP = 8'h08;
  localparam logic [7:0] OFF_EVE = 8'h0C;
  localparam logic [7:0] OFF_EVF = 8'h10;
  localparam logic [7:0] OFF_RSTART = 8'h14;
  localparam logic [7:0] OFF_CMDCNT = 8'h18;
  localparam logic [7:0] OFF_LSTART = 8'h1C;
  localparam logic [7:0] OFF_BASEA = 8'h20;
  localparam logic [7:0] OFF_BASEB = 8'h24;
  localparam logic [7:0] OFF_IOBASE = 8'h28;
  localparam logic [7:0] OFF_TRANSA = 8'h2C;
  localparam logic [7:0] OFF_TRANSB = 8'h30;
  localparam logic [7:0] OFF_BUSCFG = 8'h34;
  localparam logic [7:0] OFF_STATUS = 8'h38;
  // Control register fields.
  localparam int B_INI_EN = 0;
  localparam int B_INI_MODE = 1;
  localparam int B_KEEP_PE = 2;
  localparam int TSF_LO = 8;
  localparam int B_TXFL = 12;
  localparam int B_RXFL = 13;
  localparam int B_ABORT = 14;
  // Bus configuration fields.
  localparam int B_MEM_EN = 0;
  localparam int B_IO_EN = 1;
  // Event bit positions.
  localparam int NEV = 7;
  localparam int EV_DMAF = 0;
  localparam int EV_SERR = 1;
  localparam int EV_IPER = 2;
  localparam int EV_IFE = 3;
  localparam int EV_IIER = 4;
  localparam int EV_TIER = 5;
  localparam int EV_TBER = 6;
  // Reset values and fixed addresses.
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [31:0] INI_RESET_VAL = 32'hFFFFFFFF;
  localparam logic [3:0] TGT_RESET_VAL = 4'hF;
  localparam logic [31:0] MM_BASE = 32'hA0000000;
  localparam logic [31:0] IO_LOCAL = 32'h80000000;
  localparam logic [3:0] CBE_ALL = 4'h0;
  localparam logic [8:0] SEG_WORDS = 9'h100;
  localparam int TX_DEPTH = 8;
  typedef enum logic [2:0] {D_IDLE, D_LINK, D_WAIT, D_MEM, D_LOCK} pdt_dma_t;
  typedef enum logic [1:0] {G_NONE, G_DMA, G_TWR, G_PF} pdt_grant_t;

  // True when a local address falls in the memory-mapped bus window.
  function automatic logic pdt_in_mm(input logic [31:0] a);
    pdt_in_mm = (a >= MM_BASE);
  endfunction : pdt_in_mm

  // True for the byte-enable patterns that a target write may carry.
  function automatic logic pdt_be_ok(input logic [3:0] b);
    case (b)
      4'h7, 4'hB, 4'hD, 4'hE, 4'h3, 4'hC, 4'h0, 4'hF: pdt_be_ok = 1'b1;
      default: pdt_be_ok = 1'b0;
    endcase
  endfunction : pdt_be_ok
endpackage : pdt_pkg

// ---- hw/pdt_bridge.sv ----
// PCI DMA initiator, target controller and event reporting behind an APB register port.
`timescale 1ns/1ps
module pdt_bridge #(
  parameter int TXD = pdt_pkg::TX_DEPTH
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave port.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bootstrap pin, low selects host-bridge mode.
  input wire logic host_mode_strap_n,
  // Link clock and DMA initiator handshake.
  input wire logic pci_clk,
  output logic ini_req,
  output logic [31:0] ini_addr,
  output logic [3:0] ini_cmd,
  output logic [3:0] ini_cbe_n,
  output logic [31:0] ini_wdata,
  input wire logic ini_ack,
  input wire logic [31:0] ini_rdata,
  input wire logic serr_n,
  input wire logic ini_perr,
  input wire logic ini_fatal,
  // Remote initiator requests to the target.
  input wire logic tgt_req,
  input wire logic tgt_write,
  input wire logic tgt_cfg,
  input wire logic [31:0] tgt_addr,
  input wire logic [3:0] tgt_cbe_n,
  input wire logic [31:0] tgt_wdata,
  input wire logic tgt_par_err,
  output logic tgt_ack,
  output logic tgt_retry,
  output logic [31:0] tgt_rdata,
  // Local memory port.
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [3:0] mem_be,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  // Processor window access and interrupt.
  input wire logic cpu_mm_req,
  output logic cpu_stall,
  output logic pci_irq
);
  localparam int CW = $clog2(TXD) + 1;
  localparam int SW = 110;
  // The active-low system error pin resets to its idle level, so no false error follows reset.
  localparam logic [SW-1:0] SYNC_RST = SW'(1) << 106;
  // Local names for the state and grant codes of the package.
  localparam pdt_pkg::pdt_dma_t D_IDLE = pdt_pkg::D_IDLE, D_LINK = pdt_pkg::D_LINK, D_WAIT = pdt_pkg::D_WAIT,
    D_MEM = pdt_pkg::D_MEM, D_LOCK = pdt_pkg::D_LOCK;
  localparam pdt_pkg::pdt_grant_t G_NONE = pdt_pkg::G_NONE, G_DMA = pdt_pkg::G_DMA, G_TWR = pdt_pkg::G_TWR,
    G_PF = pdt_pkg::G_PF;

  // Two-stage synchroniser for every pin from the link domain.
  logic [SW-1:0] s1_q, s2_q;
  logic clk_prev_q, treq_prev_q;
  wire lk_rise = s2_q[109] & ~clk_prev_q;
  wire [SW-1:0] sync_in = {pci_clk, host_mode_strap_n, ini_ack, serr_n, ini_perr, ini_fatal, tgt_req,
                           tgt_write, tgt_cfg, tgt_par_err, tgt_cbe_n, ini_rdata, tgt_addr, tgt_wdata};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      clk_prev_q <= 1'b0;
      treq_prev_q <= 1'b0;
    end else begin
      s1_q <= sync_in;
      s2_q <= s1_q;
      clk_prev_q <= s2_q[109];
      if (lk_rise) treq_prev_q <= s2_q[103];
    end
  end

  // Named views of the synchronised pins.
  wire host = ~s2_q[108];
  wire ack_s = s2_q[107];
  wire serr_s = ~s2_q[106];
  wire treq_s = s2_q[103];
  wire twr_s = s2_q[102];
  wire tcfg_s = s2_q[101];
  wire tpe_s = s2_q[100];
  wire [3:0] tcbe_s = s2_q[99:96];
  wire [31:0] irdata_s = s2_q[95:64];
  wire [31:0] taddr_s = s2_q[63:32];
  wire [31:0] twdata_s = s2_q[31:0];
  wire t_new = lk_rise & treq_s & ~treq_prev_q;

  // Register state.
  logic [2:0] ctrl_q;
  logic [31:0] icfg_q, rstart_q, lstart_q, base_a_q, base_b_q, io_base_q, trans_a_q, trans_b_q, data_q;
  logic [1:0] buscfg_q;
  logic [pdt_pkg::NEV-1:0] evp_q, eve_q, ev_set;
  logic [3:0] cmd_q;
  logic [7:0] cnt_q;
  logic crossed_q, loc_given_q, ini_req_q;
  pdt_pkg::pdt_dma_t d_st;
  pdt_pkg::pdt_grant_t g_q;
  logic t_wr_q, lock_q, ack_q, retry_q;
  logic [31:0] lock_addr_q, pf_addr_q, t_waddr_q, t_wdata_q, rdata_q;
  logic [3:0] t_be_n_q;
  logic [CW-1:0] pf_cnt_q;
  logic [31:0] txf_q [TXD];

  // APB decode; every access completes in its first access cycle.
  wire apb_wr = psel & penable & pwrite;
  wire hit = (paddr <= pdt_pkg::OFF_STATUS) & (paddr[1:0] == 2'h0);
  wire w_cnt = apb_wr & (paddr == pdt_pkg::OFF_CMDCNT);
  wire w_loc = apb_wr & (paddr == pdt_pkg::OFF_LSTART);
  wire w_ctrl = apb_wr & (paddr == pdt_pkg::OFF_CTRL);
  wire w_irst = apb_wr & (paddr == pdt_pkg::OFF_ICFG) & (pwdata == pdt_pkg::INI_RESET_VAL);
  wire t_rst = w_ctrl & (pwdata[pdt_pkg::TSF_LO+:4] == pdt_pkg::TGT_RESET_VAL);
  wire [pdt_pkg::NEV-1:0] ev_clr = (apb_wr & (paddr == pdt_pkg::OFF_EVP)) ? pwdata[pdt_pkg::NEV-1:0] : '0;
  wire [pdt_pkg::NEV-1:0] ev_frc = (apb_wr & (paddr == pdt_pkg::OFF_EVF)) ? pwdata[pdt_pkg::NEV-1:0] : '0;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // DMA decode: direction, segment room and the steps that end a word.
  wire is_rd = ~cmd_q[0];
  wire ini_on = ctrl_q[pdt_pkg::B_INI_EN] & ctrl_q[pdt_pkg::B_INI_MODE];
  wire busy = (d_st == D_LINK) | (d_st == D_WAIT) | (d_st == D_MEM);
  wire [8:0] seg_left = pdt_pkg::SEG_WORDS - {1'b0, pwdata[9:2]};
  wire loc_set = w_loc & busy & ~loc_given_q & ~w_irst;
  wire loc_cancel = loc_set & pdt_pkg::pdt_in_mm(pwdata);
  wire lock_enter = w_loc & (d_st == D_IDLE) & ~w_irst;
  wire link_done = (d_st == D_LINK) & ini_req_q & ack_s;
  wire mem_done_dma = (g_q == G_DMA) & mem_ack;
  wire wdone = ((link_done & ~is_rd) | (mem_done_dma & (d_st == D_MEM) & is_rd)) & ~w_irst;
  wire last = wdone & (cnt_q == 8'h01);

  // DMA engine state machine.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_st <= D_IDLE;
      cmd_q <= 4'h0;
      cnt_q <= 8'h00;
      rstart_q <= 32'h0;
      lstart_q <= 32'h0;
      data_q <= 32'h0;
      crossed_q <= 1'b0;
      loc_given_q <= 1'b0;
      ini_req_q <= 1'b0;
    end else if (w_irst) begin
      d_st <= D_IDLE;
      ini_req_q <= 1'b0;
      loc_given_q <= 1'b0;
    end else begin
      if (apb_wr && paddr == pdt_pkg::OFF_RSTART && d_st == D_IDLE) rstart_q <= pwdata;
      case (d_st)
        D_IDLE: begin
          if (w_cnt && ini_on && pwdata[7:0] != 8'h00) begin
            cmd_q <= pwdata[11:8];
            cnt_q <= pwdata[7:0];
            loc_given_q <= 1'b0;
            d_st <= pwdata[8] ? D_WAIT : D_LINK;
          end else if (w_loc) begin
            d_st <= D_LOCK;
          end
        end
        D_LINK: begin
          if (!ini_req_q && !ack_s) begin
            ini_req_q <= 1'b1;
          end else if (link_done) begin
            ini_req_q <= 1'b0;
            if (is_rd) begin
              data_q <= irdata_s;
              d_st <= loc_given_q ? D_MEM : D_WAIT;
            end
          end
        end
        D_WAIT: if (loc_given_q) d_st <= D_MEM;
        D_MEM: begin
          if (mem_done_dma && !is_rd) begin
            data_q <= mem_rdata;
            d_st <= D_LINK;
          end
        end
        D_LOCK: d_st <= D_LOCK;
        default: d_st <= D_IDLE;
      endcase
      if (loc_set) begin
        loc_given_q <= 1'b1;
        lstart_q <= pwdata;
        crossed_q <= {1'b0, cnt_q} > seg_left;
        if ({1'b0, cnt_q} > seg_left) cnt_q <= seg_left[7:0];
      end
      if (wdone) begin
        cnt_q <= cnt_q - 8'h01;
        rstart_q <= rstart_q + 32'h4;
        lstart_q <= lstart_q + 32'h4;
        d_st <= last ? D_IDLE : (is_rd ? D_LINK : D_MEM);
      end
      if (loc_cancel) begin
        d_st <= D_IDLE;
        ini_req_q <= 1'b0; // A cancelled transfer must not leave a word request hanging on the link.
      end
    end
  end

  // Initiator outputs; the byte enables never select a partial word.
  assign ini_req = ini_req_q;
  assign ini_addr = rstart_q;
  assign ini_cmd = cmd_q;
  assign ini_cbe_n = pdt_pkg::CBE_ALL;
  assign ini_wdata = data_q;
  assign cpu_stall = cpu_mm_req & busy;

  // Target window decode and translation.
  wire hit_a = buscfg_q[pdt_pkg::B_MEM_EN] & (taddr_s[31:24] == base_a_q[31:24]);
  wire hit_b = buscfg_q[pdt_pkg::B_MEM_EN] & (taddr_s[31:24] == base_b_q[31:24]);
  wire hit_io = buscfg_q[pdt_pkg::B_IO_EN] & (taddr_s[31:10] == io_base_q[31:10]);
  wire t_hit = ~tcfg_s & (hit_a | hit_b | hit_io);
  wire [31:0] tloc = hit_a ? {trans_a_q[31:24], taddr_s[23:0]} :
                     hit_b ? {trans_b_q[31:24], taddr_s[23:0]} : (pdt_pkg::IO_LOCAL | {22'h0, taddr_s[9:0]});
  wire t_cancel = (hit_a | hit_b) & pdt_pkg::pdt_in_mm(tloc);
  wire t_bad_be = t_new & t_hit & twr_s & ~pdt_pkg::pdt_be_ok(tcbe_s);
  wire t_drop = tpe_s & ~ctrl_q[pdt_pkg::B_KEEP_PE];
  wire t_store = t_new & t_hit & twr_s & ~t_bad_be & ~t_cancel & ~t_drop & (tcbe_s != 4'hF);
  wire t_rd = t_new & t_hit & ~twr_s & ~t_cancel;
  wire cfg_wr = t_new & tcfg_s & twr_s & ~host;
  wire pf_go = lock_q & (pf_cnt_q < CW'(TXD));
  wire pf_done = (g_q == G_PF) & mem_ack;

  // Target controller: posted writes, delayed reads and the prefetch buffer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_wr_q <= 1'b0;
      lock_q <= 1'b0;
      ack_q <= 1'b0;
      retry_q <= 1'b0;
      pf_cnt_q <= '0;
      lock_addr_q <= 32'h0;
      pf_addr_q <= 32'h0;
      t_waddr_q <= 32'h0;
      t_wdata_q <= 32'h0;
      t_be_n_q <= 4'hF;
      rdata_q <= 32'h0;
    end else begin
      if (!treq_s) begin
        ack_q <= 1'b0;
        retry_q <= 1'b0;
      end
      if (pf_done && lock_q) begin
        txf_q[pf_cnt_q[CW-2:0]] <= mem_rdata;
        pf_cnt_q <= pf_cnt_q + CW'(1);
        pf_addr_q <= pf_addr_q + 32'h4;
      end
      if ((g_q == G_TWR) && mem_ack) begin
        t_wr_q <= 1'b0;
        ack_q <= 1'b1;
      end
      if (t_store) begin
        t_wr_q <= 1'b1;
        t_waddr_q <= tloc;
        t_wdata_q <= twdata_s;
        t_be_n_q <= tcbe_s;
      end else if (t_new && (tcfg_s || t_hit) && !t_rd) begin
        ack_q <= 1'b1; // Dropped, cancelled, dummy and config cycles complete at once.
        rdata_q <= 32'h0;
      end else if (t_rd) begin
        if (!lock_q) begin
          lock_q <= 1'b1;
          lock_addr_q <= taddr_s;
          pf_addr_q <= tloc;
          pf_cnt_q <= '0;
          retry_q <= 1'b1;
        end else if (taddr_s != lock_addr_q || pf_cnt_q == '0) begin
          retry_q <= 1'b1;
        end else begin
          rdata_q <= txf_q[0];
          ack_q <= 1'b1;
          lock_q <= 1'b0;
          pf_cnt_q <= '0;
        end
      end
      if (w_ctrl && pwdata[pdt_pkg::B_TXFL]) pf_cnt_q <= '0;
      if (w_ctrl && pwdata[pdt_pkg::B_RXFL]) t_wr_q <= 1'b0;
      if (w_ctrl && pwdata[pdt_pkg::B_ABORT]) begin
        lock_q <= 1'b0;
        pf_cnt_q <= '0;
      end
      if (t_rst) begin
        t_wr_q <= 1'b0;
        lock_q <= 1'b0;
        pf_cnt_q <= '0;
        ack_q <= 1'b0;
        retry_q <= 1'b0;
      end
    end
  end

  assign tgt_ack = ack_q;
  assign tgt_retry = retry_q;
  assign tgt_rdata = rdata_q;

  // Local memory arbiter; the DMA engine goes first, then target writes, then prefetch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) g_q <= G_NONE;
    else if (mem_ack) g_q <= G_NONE;
    else if (g_q == G_NONE) g_q <= (d_st == D_MEM) ? G_DMA : t_wr_q ? G_TWR : pf_go ? G_PF : G_NONE;
  end

  assign mem_req = (g_q != G_NONE);
  assign mem_we = (g_q == G_DMA) ? is_rd : (g_q == G_TWR);
  assign mem_addr = (g_q == G_DMA) ? lstart_q : (g_q == G_TWR) ? t_waddr_q : pf_addr_q;
  assign mem_be = (g_q == G_TWR) ? ~t_be_n_q : 4'hF;
  assign mem_wdata = (g_q == G_DMA) ? data_q : t_wdata_q;

  // Event sources gathered for the pending register.
  always_comb begin
    ev_set = '0;
    ev_set[pdt_pkg::EV_DMAF] = last;
    ev_set[pdt_pkg::EV_SERR] = lk_rise & serr_s;
    ev_set[pdt_pkg::EV_IPER] = lk_rise & s2_q[105];
    ev_set[pdt_pkg::EV_IFE] = lk_rise & s2_q[104];
    ev_set[pdt_pkg::EV_IIER] = (last & crossed_q) | loc_cancel | lock_enter;
    ev_set[pdt_pkg::EV_TIER] = t_new & t_hit & t_cancel;
    ev_set[pdt_pkg::EV_TBER] = t_bad_be;
  end

  // Software registers; set and force win over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= pdt_pkg::CTRL_RST;
      icfg_q <= 32'h0;
      evp_q <= '0;
      eve_q <= '0;
      base_a_q <= 32'h0;
      base_b_q <= 32'h0;
      io_base_q <= 32'h0;
      trans_a_q <= 32'h0;
      trans_b_q <= 32'h0;
      buscfg_q <= 2'h0;
    end else begin
      evp_q <= (evp_q & ~ev_clr) | ev_set | ev_frc;
      if (apb_wr) begin
        case (paddr)
          pdt_pkg::OFF_CTRL: ctrl_q <= pwdata[2:0];
          pdt_pkg::OFF_ICFG: icfg_q <= w_irst ? 32'h0 : pwdata;
          pdt_pkg::OFF_EVE: eve_q <= pwdata[pdt_pkg::NEV-1:0];
          pdt_pkg::OFF_TRANSA: trans_a_q <= pwdata;
          pdt_pkg::OFF_TRANSB: trans_b_q <= pwdata;
          pdt_pkg::OFF_BASEA: if (host) base_a_q <= pwdata;
          pdt_pkg::OFF_BASEB: if (host) base_b_q <= pwdata;
          pdt_pkg::OFF_IOBASE: if (host) io_base_q <= pwdata;
          pdt_pkg::OFF_BUSCFG: if (host) buscfg_q <= pwdata[1:0];
          default: ;
        endcase
      end else if (cfg_wr) begin
        case (taddr_s[3:2])
          2'h0: base_a_q <= twdata_s;
          2'h1: base_b_q <= twdata_s;
          2'h2: io_base_q <= twdata_s;
          default: buscfg_q <= twdata_s[1:0];
        endcase
      end
    end
  end

  assign pci_irq = |(evp_q & eve_q);

  // Read data selection.
  always_comb begin
    case (paddr)
      pdt_pkg::OFF_CTRL: prdata = {29'h0, ctrl_q};
      pdt_pkg::OFF_ICFG: prdata = icfg_q;
      pdt_pkg::OFF_EVP: prdata = {25'h0, evp_q};
      pdt_pkg::OFF_EVE: prdata = {25'h0, eve_q};
      pdt_pkg::OFF_RSTART: prdata = rstart_q;
      pdt_pkg::OFF_CMDCNT: prdata = {20'h0, cmd_q, cnt_q};
      pdt_pkg::OFF_LSTART: prdata = lstart_q;
      pdt_pkg::OFF_BASEA: prdata = base_a_q;
      pdt_pkg::OFF_BASEB: prdata = base_b_q;
      pdt_pkg::OFF_IOBASE: prdata = io_base_q;
      pdt_pkg::OFF_TRANSA: prdata = trans_a_q;
      pdt_pkg::OFF_TRANSB: prdata = trans_b_q;
      pdt_pkg::OFF_BUSCFG: prdata = {30'h0, buscfg_q};
      pdt_pkg::OFF_STATUS: prdata = {19'h0, host, d_st, lock_q, t_wr_q, pf_cnt_q, 3'h0};
      default: prdata = 32'h0;
    endcase
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_loc_bad;
    w_loc && busy && !loc_given_q && !w_irst && pdt_pkg::pdt_in_mm(pwdata);
  endsequence
  sequence s_cancelled;
    (d_st == D_IDLE) ##1 evp_q[pdt_pkg::EV_IIER];
  endsequence
  AST_CBE_ZERO: assert property (ini_req |-> ini_cbe_n == 4'h0) else $error("partial byte enables");
  AST_STALL: assert property (cpu_mm_req && d_st == D_MEM |-> cpu_stall) else $error("no stall");
  AST_STICKY: assert property (evp_q[pdt_pkg::EV_DMAF] && !ev_clr[pdt_pkg::EV_DMAF]
                               |=> evp_q[pdt_pkg::EV_DMAF]) else $error("flag lost");
  AST_FORCE_IRQ: assert property (ev_frc[pdt_pkg::EV_TBER] && eve_q[pdt_pkg::EV_TBER] && !ev_clr[pdt_pkg::EV_TBER]
                                  |=> evp_q[pdt_pkg::EV_TBER] && pci_irq) else $error("force no irq");
  AST_PREFETCH: assert property (d_st == D_IDLE && w_cnt && ini_on && !pwdata[8] && pwdata[7:0] != 8'h00
                                 |=> d_st == D_LINK ##[1:3] ini_req) else $error("no prefetch");
  AST_LOC_CANCEL: assert property (s_loc_bad |=> s_cancelled) else $error("window not cancelled");
  AST_INI_RESET: assert property (w_irst |=> d_st == D_IDLE && !ini_req) else $error("no reset");
  AST_TX_BOUND: assert property (pf_cnt_q <= CW'(TXD)) else $error("prefetch overrun");
  AST_BAD_BE: assert property (t_bad_be |=> evp_q[pdt_pkg::EV_TBER] && !t_wr_q) else $error("bad be");
  AST_LOCK_RETRY: assert property (t_rd && lock_q && taddr_s != lock_addr_q && !t_rst
                                   |=> retry_q && !ack_q) else $error("other read served");
endmodule : pdt_bridge

// ---- verif/pdt_far_model.sv ----
// Far-end model of a remote bus target that answers DMA word requests.
`timescale 1ns/1ps
module pdt_far_model #(
  parameter int LAT = 2
) (
  // Clock.
  input wire logic pclk,
  // DMA word handshake.
  input wire logic ini_req,
  input wire logic [31:0] ini_addr,
  output logic ini_ack,
  output logic [31:0] ini_rdata
);
  int n = 0;
  initial ini_ack = 1'h0;
  initial ini_rdata = 32'h0;
  // Acknowledges after LAT+1 cycles and drops the data once the request is released.
  always @(posedge pclk) begin
    if (ini_req && !ini_ack) begin
      n <= n + 1;
      if (n >= LAT) begin
        ini_ack <= 1'h1;
        ini_rdata <= ini_addr ^ 32'h5A5A0000;
      end
    end else if (!ini_req && ini_ack) begin
      ini_ack <= 1'h0;
      ini_rdata <= ~ini_rdata; // Released data is not held.
      n <= 0;
    end
  end
endmodule : pdt_far_model

// ---- verif/pci_dma_target_bridge_tb.sv ----
// Self-checking bench of the bridge: registers, events, DMA and target writes.
`timescale 1ns/1ps
module pci_dma_target_bridge_tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic x;} pdt_row_t;
  logic pclk = 0, presetn = 0, pci_clk = 0, psel = 0, penable = 0, pwrite = 0, cpu_mm_req = 0;
  logic mem_ack = 0, tgt_req = 0, tgt_par_err = 0, tgt_write = 0, req_d = 0, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, mem_rdata = 0, tgt_addr = 0, tgt_wdata = 0, r, exp_ra;
  logic [31:0] prdata, ini_addr, ini_wdata, ini_rdata, tgt_rdata, mem_addr, mem_wdata;
  logic pready, pslverr, ini_req, ini_ack, tgt_ack, tgt_retry, mem_req, mem_we, pci_irq, cpu_stall;
  logic [3:0] tgt_cbe_n = 0, ini_cmd, ini_cbe_n, mem_be;
  logic [31:0] wa[$], wd[$];
  int mismatches = 0, checks_done = 0;
  // System clock and an unrelated link clock.
  initial forever #25 pclk = ~pclk;
  initial begin
    #7;
    forever #200 pci_clk = ~pci_clk;
  end
  pdt_bridge i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .host_mode_strap_n(1'h0), .pci_clk, .ini_req, .ini_addr, .ini_cmd, .ini_cbe_n, .ini_wdata, .ini_ack,
    .ini_rdata, .serr_n(1'h1), .ini_perr(1'h0), .ini_fatal(1'h0), .tgt_req, .tgt_write, .tgt_cfg(1'h0),
    .tgt_addr, .tgt_cbe_n, .tgt_wdata, .tgt_par_err, .tgt_ack, .tgt_retry, .tgt_rdata, .mem_req, .mem_we,
    .mem_addr, .mem_be, .mem_wdata, .mem_rdata, .mem_ack, .cpu_mm_req, .cpu_stall, .pci_irq);
  pdt_far_model i_far (.pclk, .ini_req, .ini_addr, .ini_ack, .ini_rdata);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic bust();
    chk(32'h0, 32'h1);
    close_out();
  endtask : bust
  // Memory answers one cycle after each request and logs the writes.
  always @(posedge pclk) begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= mem_addr;
    req_d <= ini_req;
    if (mem_req && !mem_ack && mem_we) begin
      wa.push_back(mem_addr);
      wd.push_back(mem_wdata);
      chk(32'(mem_be), 32'hF);
    end
    if (ini_req && !req_d) begin
      chk(32'(ini_cbe_n), 32'h0);
      chk(ini_addr, exp_ra);
      exp_ra = exp_ra + 32'h4;
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k >= 20) bust();
    @(posedge pclk);
  endtask : apb
  task automatic wait_ev(input int b);
    int k;
    for (k = 0; k < 300; k++) begin
      apb(1'h0, pdt_pkg::OFF_EVP, 32'h0);
      if (r[b] === 1'h1) break;
    end
    if (k >= 300) bust();
  endtask : wait_ev
  task automatic dma(input logic [31:0] ra, input logic [31:0] cc, input logic [31:0] la);
    exp_ra = ra;
    apb(1'h1, pdt_pkg::OFF_EVP, 32'h7F);
    apb(1'h1, pdt_pkg::OFF_RSTART, ra);
    apb(1'h1, pdt_pkg::OFF_CMDCNT, cc);
    apb(1'h1, pdt_pkg::OFF_LSTART, la);
  endtask : dma
  task automatic tgt_wait(input logic v);
    int k;
    for (k = 0; k < 200 && (tgt_ack | tgt_retry) !== v; k++) @(posedge pclk);
    if (k >= 200) bust();
    // A released request stays low for more than one link clock period, so the next one is seen as new.
    if (!v) repeat (12) @(posedge pclk);
  endtask : tgt_wait
  // Main sequence: register table, events, DMA cases, target writes.
  initial begin
    pdt_row_t rows[6];
    int i;
    rows[0] = '{pdt_pkg::OFF_EVE, 32'h7F, 32'h7F, 1'h0};
    rows[1] = '{pdt_pkg::OFF_BASEA, 32'h01000000, 32'h01000000, 1'h0};
    rows[2] = '{pdt_pkg::OFF_TRANSA, 32'h02000000, 32'h02000000, 1'h0};
    rows[3] = '{pdt_pkg::OFF_BUSCFG, 32'h1, 32'h1, 1'h0};
    rows[4] = '{pdt_pkg::OFF_RSTART, 32'h12345678, 32'h12345678, 1'h0};
    rows[5] = '{8'h3C, 32'h55, 32'h0, 1'h1};
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, pdt_pkg::OFF_EVP, 32'h0);
    chk(r, 32'h0);
    chk(32'(pci_irq), 32'h0);
    for (i = 0; i < 6; i++) begin
      apb(1'h1, rows[i].a, rows[i].d);
      apb(1'h0, rows[i].a, 32'h0);
      chk(r, rows[i].e);
      chk(32'(err), 32'(rows[i].x));
    end
    $display("test registers done");
    apb(1'h1, pdt_pkg::OFF_EVF, 32'h41);
    apb(1'h0, pdt_pkg::OFF_EVP, 32'h0);
    chk(r, 32'h41);
    chk(32'(pci_irq), 32'h1);
    apb(1'h1, pdt_pkg::OFF_EVE, 32'h0);
    chk(32'(pci_irq), 32'h0);
    apb(1'h1, pdt_pkg::OFF_EVP, 32'h1);
    apb(1'h0, pdt_pkg::OFF_EVP, 32'h0);
    chk(r, 32'h40);
    $display("test events done");
    apb(1'h1, pdt_pkg::OFF_CTRL, 32'h3);
    cpu_mm_req <= 1'h1;
    dma(32'h100, 32'h602, 32'h1000);
    chk(32'(cpu_stall), 32'h1);
    wait_ev(pdt_pkg::EV_DMAF);
    chk(32'(cpu_stall), 32'h0);
    chk(r, 32'h1);
    for (i = 0; i < 2; i++) begin
      chk(wa[i], 32'h1000 + 32'(4 * i));
      chk(wd[i], (32'h100 + 32'(4 * i)) ^ 32'h5A5A0000);
    end
    wa.delete();
    dma(32'h200, 32'h603, 32'h13F8);
    wait_ev(pdt_pkg::EV_DMAF);
    wait_ev(pdt_pkg::EV_IIER);
    chk(r, 32'h11);
    chk(32'(wa.size()), 32'h2);
    wa.delete();
    dma(32'h300, 32'h601, pdt_pkg::MM_BASE);
    wait_ev(pdt_pkg::EV_IIER);
    chk(32'(wa.size()), 32'h0);
    apb(1'h1, pdt_pkg::OFF_ICFG, pdt_pkg::INI_RESET_VAL);
    apb(1'h1, pdt_pkg::OFF_EVP, 32'h7F);
    apb(1'h1, pdt_pkg::OFF_LSTART, 32'h1000);
    wait_ev(pdt_pkg::EV_IIER);
    apb(1'h1, pdt_pkg::OFF_ICFG, pdt_pkg::INI_RESET_VAL);
    apb(1'h1, pdt_pkg::OFF_CTRL, 32'h3);
    dma(32'h400, 32'h601, 32'h1800);
    wait_ev(pdt_pkg::EV_DMAF);
    chk(r, 32'h1);
    // Write command: one word read from local memory and sent to a high remote address.
    dma(32'h80000800, 32'h701, 32'h1900);
    wait_ev(pdt_pkg::EV_DMAF);
    chk(ini_wdata, 32'h1900);
    chk(32'(ini_cmd), 32'h7);
    $display("test dma done");
    cpu_mm_req <= 1'h0;
    for (i = 0; i < 4; i++) begin
      wa.delete();
      if (i == 3) apb(1'h1, pdt_pkg::OFF_TRANSA, pdt_pkg::MM_BASE);
      apb(1'h1, pdt_pkg::OFF_EVP, 32'h7F);
      tgt_write <= 1'h1;
      tgt_addr <= 32'h01000010;
      tgt_wdata <= 32'hC0DE0000;
      tgt_cbe_n <= (i == 1) ? 4'h5 : 4'h0;
      tgt_par_err <= (i == 2);
      tgt_req <= 1'h1;
      tgt_wait(1'h1);
      tgt_req <= 1'h0;
      tgt_wait(1'h0);
      apb(1'h0, pdt_pkg::OFF_EVP, 32'h0);
      chk(32'(r[6]), 32'(i == 1));
      chk(32'(r[5]), 32'(i == 3));
      chk(32'(wa.size()), 32'(i == 0));
      if (i == 0) chk(wa[0], 32'h02000010);
    end
    // Delayed reads: retry, lock against another address, completion, then a target reset.
    apb(1'h1, pdt_pkg::OFF_TRANSA, 32'h02000000);
    for (i = 0; i < 6; i++) begin
      if (i == 4) apb(1'h1, pdt_pkg::OFF_CTRL, 32'h4F03);
      tgt_write <= 1'h0;
      tgt_addr <= (i == 1 || i > 3) ? 32'h01000024 : 32'h01000020;
      tgt_req <= 1'h1;
      tgt_wait(1'h1);
      chk(32'(tgt_retry), 32'(i != 2 && i != 5));
      tgt_req <= 1'h0;
      tgt_wait(1'h0);
      if (i == 2 || i == 5) chk(tgt_rdata, (i == 2) ? 32'h02000020 : 32'h02000024);
    end
    $display("test target done");
    close_out();
  end
endmodule : pci_dma_target_bridge_tb
